// File: result_fifo.sv
// result word fifo between conversion and serial shifter
`timescale 1ns/10ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             flush,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             inReady,
  output var  logic             outValid,
  output var  logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [CW-1:0]               count;
  } fifo_st_t;

  fifo_st_t s_r;
  fifo_st_t s_nxt;
  logic     push;
  logic     pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  assign inReady  = (s_r.count != CW'(DEPTH));
  assign outValid = (s_r.count != '0);
  assign outData  = s_r.mem[s_r.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    s_nxt = s_r;
    if (flush) begin
      s_nxt.wrPtr = '0;
      s_nxt.rdPtr = '0;
      s_nxt.count = '0;
    end else begin
      if (push) begin
        s_nxt.mem[s_r.wrPtr] = inData;
        s_nxt.wrPtr          = bump(s_r.wrPtr);
      end
      if (pop) begin
        s_nxt.rdPtr = bump(s_r.rdPtr);
      end
      if (push && !pop) begin
        s_nxt.count = s_r.count + CW'(1);
      end else if (pop && !push) begin
        s_nxt.count = s_r.count - CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : result_fifo
`default_nettype wire

// File: sar_adc_serial_readout.sv
// conversion control and double-data-rate serial readout of a 16-bit converter
`timescale 1ns/10ps
`default_nettype none
module sar_adc_serial_readout
  import sar_readout_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              powerDownN,
  input  wire logic              supplyGood,
  input  wire logic              convertStrobe,
  input  wire logic              readoutClock,
  input  wire logic              dualLaneSelect,
  input  wire logic              patternForce,
  input  wire logic [WORD_W-1:0] quantiserCode,
  output var  logic              echoedClockOut,
  output var  logic              firstSerialLane,
  output var  logic              secondSerialLane,
  output var  logic              echoEnable,
  output var  logic              firstLaneEnable,
  output var  logic              secondLaneEnable,
  output var  logic              resultInvalid,
  output var  logic              converting
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic              pdS1;
    logic              pdS2;
    logic              supS1;
    logic              supS2;
    logic              cnvS1;
    logic              cnvS2;
    logic              cnvPrev;
    logic              clkS1;
    logic              clkS2;
    logic              clkPrev;
    logic              dualS1;
    logic              dualS2;
    logic              patS1;
    logic              patS2;
    phase_t            phase;
    logic [CNT_W-1:0]  convCnt;
    logic [WORD_W-1:0] sample;
    logic [1:0]        invalidLeft;
    logic [WORD_W-1:0] shifter;
    logic [4:0]        edgesLeft;
    logic              wordDual;
    logic              echo;
    logic              laneA;
    logic              laneB;
    logic              enA;
    logic              enB;
    logic              curInvalid;
    logic              conv;
  } st_t;

  st_t     s_r;
  st_t     s_nxt;
  logic    alive;
  logic    cnvRise;
  logic    clkEdge;
  logic    pushValid;
  result_t pushWord;
  logic    fifoInReady;
  logic    fifoOutValid;
  result_t fifoOut;
  logic    popReady;
  logic    popFire;

  // shift by one bit per edge on one lane, two bits on two lanes
  function automatic logic [WORD_W-1:0] shiftWord(input logic [WORD_W-1:0] w,
                                                  input logic dual);
    shiftWord = dual ? {w[WORD_W-3:0], 2'h0} : {w[WORD_W-2:0], 1'h0};
  endfunction : shiftWord

  function automatic logic laneBitB(input logic [WORD_W-1:0] w, input logic dual);
    laneBitB = dual & w[NEXT_B];
  endfunction : laneBitB

  // -----------------------------------------------------------------
  // combinational helpers
  // -----------------------------------------------------------------
  assign alive   = s_r.pdS2 && s_r.supS2;
  assign cnvRise = s_r.cnvS2 && !s_r.cnvPrev;
  assign clkEdge = s_r.clkS2 ^ s_r.clkPrev;
  // the next word loads only once the current one has shifted out
  assign popReady = alive && (s_r.edgesLeft == '0);
  assign popFire  = popReady && fifoOutValid;

  always_comb begin
    pushValid        = alive && (s_r.phase == PH_CONV) && (s_r.convCnt == CONV_LAST);
    pushWord.invalid = (s_r.invalidLeft != '0);
    if (s_r.patS2) begin
      pushWord.data = s_r.dualS2 ? PATTERN_TWO_LANE : PATTERN_ONE_LANE;
    end else begin
      pushWord.data = s_r.sample;
    end
  end

  result_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rstn     (rstn),
    .flush    (!alive),
    .inValid  (pushValid),
    .inData   (pushWord),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOut),
    .outReady (popReady)
  );

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    s_nxt         = s_r;
    s_nxt.pdS1    = powerDownN;
    s_nxt.pdS2    = s_r.pdS1;
    s_nxt.supS1   = supplyGood;
    s_nxt.supS2   = s_r.supS1;
    s_nxt.cnvS1   = convertStrobe;
    s_nxt.cnvS2   = s_r.cnvS1;
    s_nxt.cnvPrev = s_r.cnvS2;
    s_nxt.clkS1   = readoutClock;
    s_nxt.clkS2   = s_r.clkS1;
    s_nxt.clkPrev = s_r.clkS2;
    s_nxt.dualS1  = dualLaneSelect;
    s_nxt.dualS2  = s_r.dualS1;
    s_nxt.patS1   = patternForce;
    s_nxt.patS2   = s_r.patS1;
    if (!alive) begin
      // everything off; strobes fall on the floor
      s_nxt.phase       = PH_OFF;
      s_nxt.convCnt     = '0;
      s_nxt.invalidLeft = INVALID_CONVS;
      s_nxt.shifter     = '0;
      s_nxt.edgesLeft   = '0;
      s_nxt.echo        = 1'h0;
      s_nxt.laneA       = 1'h0;
      s_nxt.laneB       = 1'h0;
      s_nxt.enA         = 1'h0;
      s_nxt.enB         = 1'h0;
      s_nxt.curInvalid  = 1'h0;
      s_nxt.conv        = 1'h0;
    end else begin
      s_nxt.enA  = 1'h1;
      s_nxt.enB  = s_r.dualS2;
      s_nxt.echo = s_r.clkS2;
      case (s_r.phase)
        PH_OFF: begin
          s_nxt.phase = PH_IDLE;
        end
        PH_IDLE: begin
          if (cnvRise) begin
            s_nxt.phase   = PH_CONV;
            s_nxt.convCnt = '0;
            s_nxt.sample  = quantiserCode;
          end
        end
        PH_CONV: begin
          // a full queue holds the finished result and keeps converting high
          if (s_r.convCnt != CONV_LAST) begin
            s_nxt.convCnt = s_r.convCnt + CNT_W'(1);
          end else if (fifoInReady) begin
            if (s_r.invalidLeft != '0) begin
              s_nxt.invalidLeft = s_r.invalidLeft - 2'h1;
            end
            // acquisition overlaps readout, so a strobe may restart at once
            if (cnvRise) begin
              s_nxt.convCnt = '0;
              s_nxt.sample  = quantiserCode;
            end else begin
              s_nxt.phase = PH_IDLE;
            end
          end
        end
        default: begin
          s_nxt.phase = PH_OFF;
        end
      endcase
      s_nxt.conv = (s_nxt.phase == PH_CONV);
      // shifter runs independently of conversion so readout may overlap
      if (popFire) begin
        s_nxt.shifter    = fifoOut.data;
        s_nxt.wordDual   = s_r.dualS2;
        s_nxt.edgesLeft  = s_r.dualS2 ? EDGES_TWO_LANE : EDGES_ONE_LANE;
        s_nxt.laneA      = fifoOut.data[MSB];
        s_nxt.laneB      = laneBitB(fifoOut.data, s_r.dualS2);
        s_nxt.curInvalid = fifoOut.invalid;
      end else if (clkEdge && (s_r.edgesLeft != '0)) begin
        s_nxt.shifter   = shiftWord(s_r.shifter, s_r.wordDual);
        s_nxt.edgesLeft = s_r.edgesLeft - 5'h01;
        s_nxt.laneA     = s_nxt.shifter[MSB];
        s_nxt.laneB     = laneBitB(s_nxt.shifter, s_r.wordDual);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign echoedClockOut   = s_r.echo;
  assign firstSerialLane  = s_r.laneA;
  assign secondSerialLane = s_r.laneB;
  assign echoEnable       = s_r.enA;
  assign firstLaneEnable  = s_r.enA;
  assign secondLaneEnable = s_r.enB;
  assign resultInvalid    = s_r.curInvalid;
  assign converting       = s_r.conv;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  localparam int CONV_BOUND = CONV_CYCLES;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence convBegin;
    alive && (s_r.phase == PH_IDLE) && cnvRise && fifoInReady;
  endsequence

  sequence shiftEdge;
    alive && !popFire && clkEdge && (s_r.edgesLeft > 5'h01) && !s_r.wordDual;
  endsequence

  pd_outputs_off_a: assert property (
    !s_r.pdS2 |=> !firstLaneEnable && !echoEnable && !secondLaneEnable && !converting)
    else $error("outputs not off in power-down");

  pd_ignore_strobe_a: assert property (
    (!alive && cnvRise) |=> (s_r.phase == PH_OFF) && !converting)
    else $error("strobe taken during power-down");

  supply_reinit_a: assert property (
    !s_r.supS2 |=> (s_r.phase == PH_OFF) && (s_r.invalidLeft == INVALID_CONVS))
    else $error("no reinitialisation on supply loss");

  conv_start_a: assert property (
    convBegin |=> converting && (s_r.convCnt == '0))
    else $error("strobe edge did not start conversion");

  conv_time_a: assert property (
    convBegin |-> ##[1:CONV_BOUND] pushValid)
    else $error("conversion exceeded its time");

  invalid_first_a: assert property (
    (pushValid && (s_r.invalidLeft != '0) && !s_r.patS2) |-> pushWord.invalid)
    else $error("early result not marked invalid");

  msb_first_a: assert property (
    popFire |=> (firstSerialLane == $past(fifoOut.data[MSB])) && (s_r.edgesLeft != '0))
    else $error("msb not on first lane after load");

  ddr_shift_a: assert property (
    shiftEdge |=> firstSerialLane == $past(s_r.shifter[NEXT_B]))
    else $error("lane not advanced on readout edge");

  echo_align_a: assert property (
    (alive && !popFire && !clkEdge && $stable(s_r.pdS2)) |=> $stable(firstSerialLane)
      && $stable(echoedClockOut))
    else $error("data moved without echo edge");

  dual_lane_a: assert property (
    (alive && s_r.dualS2) [*2] |=> secondLaneEnable)
    else $error("second lane not enabled");

  pattern_word_a: assert property (
    (pushValid && s_r.patS2) |-> pushWord.data ==
      (s_r.dualS2 ? PATTERN_TWO_LANE : PATTERN_ONE_LANE))
    else $error("test pattern wrong");

  overlap_a: assert property (
    (convBegin and (s_r.edgesLeft != '0) && !clkEdge && !popFire) |=>
      converting && (s_r.edgesLeft == $past(s_r.edgesLeft)))
    else $error("readout disturbed by new conversion");

  // -----------------------------------------------------------------
  // checks of the shifter, the conversion count and the idle outputs
  // -----------------------------------------------------------------
  localparam int PAIR_HI = WORD_W - 3;
  localparam int PAIR_LO = WORD_W - 4;

  sequence dualEdge;
    alive && !popFire && clkEdge && (s_r.edgesLeft != '0) && s_r.wordDual;
  endsequence

  dual_shift_a: assert property (
    dualEdge |=> (firstSerialLane == $past(s_r.shifter[PAIR_HI]))
      && (secondSerialLane == $past(s_r.shifter[PAIR_LO])))
    else $error("lane pair not advanced on readout edge");

  edge_count_a: assert property (
    (alive && clkEdge && !popFire && (s_r.edgesLeft != '0)) |=>
      (s_r.edgesLeft == $past(s_r.edgesLeft) - 5'h01))
    else $error("readout edge not counted");

  lane_b_quiet_a: assert property (
    (!s_r.wordDual && !popFire) |=> !secondSerialLane)
    else $error("second lane active in one-lane word");

  lane_load_b_a: assert property (
    popFire |=> secondSerialLane == ($past(s_r.dualS2) && $past(fifoOut.data[NEXT_B])))
    else $error("second lane wrong after load");

  conv_hold_a: assert property (
    (alive && (s_r.phase == PH_CONV) && (s_r.convCnt != CONV_LAST)) |=>
      converting && (s_r.convCnt == $past(s_r.convCnt) + CNT_W'(1)))
    else $error("conversion count stalled");

  conv_end_a: assert property (
    (pushValid && fifoInReady && !cnvRise) |=> !converting)
    else $error("conversion did not end after push");

  invalid_count_a: assert property (
    (pushValid && fifoInReady && (s_r.invalidLeft != '0)) |=>
      (s_r.invalidLeft == $past(s_r.invalidLeft) - 2'h1))
    else $error("invalid result count not decremented");

  echo_follow_a: assert property (
    (alive && clkEdge) |=> (echoedClockOut == $past(s_r.clkS2)))
    else $error("echo did not follow readout edge");

  off_lanes_a: assert property (
    !alive |=> !firstSerialLane && !secondSerialLane && !echoedClockOut && !resultInvalid)
    else $error("lanes active in power-down");

  enable_on_a: assert property (
    alive |=> firstLaneEnable && echoEnable)
    else $error("outputs not back on after wake");
endmodule : sar_adc_serial_readout
`default_nettype wire

// File: sar_adc_serial_readout_tb_top.sv
// self-checking bench of the converter readout against the host model
`timescale 1ns/10ps
`default_nettype none
module sar_adc_serial_readout_tb_top;
  import sar_readout_pkg::*;
  logic              clk, rstn, powerDownN, supplyGood, dualLaneSelect, patternForce;
  logic [WORD_W-1:0] quantiserCode;
  logic              strobeReq, burstReq, convertStrobe, readoutClock, burstBusy, wordValid;
  logic              echoedClockOut, firstSerialLane, secondSerialLane, echoEnable;
  logic              firstLaneEnable, secondLaneEnable, resultInvalid, converting;
  result_t           wordOut;
  result_t           expQ[$];
  int                err_count, check_count, n;
  logic [31:0]       seed;

  sar_adc_serial_readout i_dut (.clk(clk), .rstn(rstn), .powerDownN(powerDownN),
    .supplyGood(supplyGood), .convertStrobe(convertStrobe), .readoutClock(readoutClock),
    .dualLaneSelect(dualLaneSelect), .patternForce(patternForce),
    .quantiserCode(quantiserCode), .echoedClockOut(echoedClockOut),
    .firstSerialLane(firstSerialLane), .secondSerialLane(secondSerialLane),
    .echoEnable(echoEnable), .firstLaneEnable(firstLaneEnable),
    .secondLaneEnable(secondLaneEnable), .resultInvalid(resultInvalid), .converting(converting));

  sar_host_model i_host (.clk(clk), .rstn(rstn), .strobeReq(strobeReq), .burstReq(burstReq),
    .dualMode(dualLaneSelect), .echoedClockOut(echoedClockOut),
    .firstSerialLane(firstSerialLane), .secondSerialLane(secondSerialLane),
    .resultInvalid(resultInvalid), .convertStrobe(convertStrobe),
    .readoutClock(readoutClock), .burstBusy(burstBusy), .wordValid(wordValid),
    .wordOut(wordOut));

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check_val(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_val

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // bounded wait for converting (0) or the host burst (1) to reach a level
  task automatic wait_lvl(input int w, input logic lvl, output int cyc);
    for (cyc = 0; cyc < 300 && (w == 0 ? converting : burstBusy) !== lvl; cyc++) @(posedge clk);
    if ((w == 0 ? converting : burstBusy) !== lvl) begin
      err_count++;
      $display("FAIL wait %0d never reached %b", w, lvl);
      complete_run();
    end
  endtask : wait_lvl

  task automatic req(input bit strobe);
    @(posedge clk);
    if (strobe) strobeReq <= 1'b1;
    else burstReq <= 1'b1;
    @(posedge clk);
    strobeReq <= 1'b0;
    burstReq  <= 1'b0;
  endtask : req

  task automatic burst(input bit hold);
    req(1'b0);
    @(posedge clk);
    if (hold) wait_lvl(1, 1'b0, n);
  endtask : burst

  task automatic conv(input logic [15:0] code, input logic inv, input bit chk);
    logic [15:0] d;
    d = patternForce ? (dualLaneSelect ? PATTERN_TWO_LANE : PATTERN_ONE_LANE) : code;
    @(posedge clk);
    quantiserCode <= code;
    expQ.push_back('{invalid: inv, data: d});
    req(1'b1);
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    check_val("conversion cycles", n, CONV_CYCLES);
    if (chk) begin
      repeat (3) @(posedge clk);
      check_val("msb before clock", firstSerialLane, d[15]);
      check_val("second lane enable", secondLaneEnable, dualLaneSelect);
    end
  endtask : conv

  task automatic wake3;
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      conv(seed[15:0], i < 2, 1'b1);
      burst(1'b1);
    end
  endtask : wake3

  task automatic sleep(input bit viaSupply);
    int hits;
    @(posedge clk);
    if (viaSupply) supplyGood <= 1'b0;
    else powerDownN <= 1'b0;
    repeat (4) @(posedge clk);
    check_val("enables off", {echoEnable, firstLaneEnable, secondLaneEnable}, 0);
    req(1'b1);
    hits = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      hits += (converting !== 1'b0);
    end
    check_val("conversion in sleep", hits, 0);
    burst(1'b1);
    @(posedge clk);
    supplyGood <= 1'b1;
    powerDownN <= 1'b1;
    // settle wait scaled down from milliseconds to keep the run short
    repeat (WAKE_SETTLE_MS * 10) @(posedge clk);
    wake3();
  endtask : sleep

  // -----------------------------------------------------------------
  // result monitor
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    if (wordValid === 1'b1) begin
      if (expQ.size() == 0) check_val("unexpected word", 1, 0);
      else check_val("word", wordOut, expQ.pop_front());
    end
  end

  // -----------------------------------------------------------------
  // clock, timeout and sequence
  // -----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("FAIL timeout");
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    powerDownN = 1'b1;
    supplyGood = 1'b1;
    dualLaneSelect = 1'b0;
    patternForce = 1'b0;
    quantiserCode = 16'h0000;
    strobeReq = 1'b0;
    burstReq = 1'b0;
    err_count = 0;
    check_count = 0;
    seed = 32'h3732;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    wake3();
    for (int m = 0; m < 4; m++) begin
      dualLaneSelect <= m[0];
      patternForce   <= m[1];
      repeat (4) @(posedge clk);
      seed = lfsr(seed);
      conv(seed[15:0], 1'b0, 1'b1);
      burst(1'b1);
    end
    @(posedge clk);
    dualLaneSelect <= 1'b0;
    patternForce   <= 1'b0;
    repeat (4) @(posedge clk);
    conv(16'h8001, 1'b0, 1'b1);
    burst(1'b0);
    repeat (20) @(posedge clk);
    conv(16'h7FFE, 1'b0, 1'b0);
    wait_lvl(1, 1'b0, n);
    burst(1'b1);
    dualLaneSelect <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      conv(seed[15:0], 1'b0, 1'b0);
    end
    for (int i = 0; i < 8; i++) burst(1'b1);
    sleep(1'b0);
    sleep(1'b1);
    check_val("words left", expQ.size(), 0);
    complete_run();
  end
endmodule : sar_adc_serial_readout_tb_top
`default_nettype wire

// File: sar_host_model.sv
// host-side model: strobes conversions, bursts the readout clock, captures words
`timescale 1ns/10ps
`default_nettype none
module sar_host_model
  import sar_readout_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rstn,
  input  wire logic    strobeReq,
  input  wire logic    burstReq,
  input  wire logic    dualMode,
  input  wire logic    echoedClockOut,
  input  wire logic    firstSerialLane,
  input  wire logic    secondSerialLane,
  input  wire logic    resultInvalid,
  output var  logic    convertStrobe,
  output var  logic    readoutClock,
  output var  logic    burstBusy,
  output var  logic    wordValid,
  output var  result_t wordOut
);
  logic       echoPrev;
  logic       laneAPrev;
  logic       laneBPrev;
  logic [4:0] edgeCnt;
  result_t    shiftWord;

  // -----------------------------------------------------------------
  // strobe and readout clock
  // -----------------------------------------------------------------
  // four-cycle strobe; the bench keeps requests apart
  initial begin
    convertStrobe = 1'b0;
    forever begin
      @(posedge clk);
      if (strobeReq) begin
        convertStrobe <= 1'b1;
        repeat (4) @(posedge clk);
        convertStrobe <= 1'b0;
      end
    end
  end

  // clock stands low between frames; 80 ns period, edges 4 ns after a clk rising edge
  initial begin
    readoutClock = 1'b0;
    burstBusy    = 1'b0;
    forever begin
      @(posedge clk);
      if (burstReq) begin
        #1;
        burstBusy = 1'b1;
        #3;
        repeat (dualMode ? 8 : 16) begin
          readoutClock = ~readoutClock;
          #40;
        end
        repeat (8) @(posedge clk);
        #1;
        burstBusy = 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // capture
  // -----------------------------------------------------------------
  // lanes move with the echo, so the bit taken is the one shown before the edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      echoPrev  <= 1'b0;
      laneAPrev <= 1'b0;
      laneBPrev <= 1'b0;
      edgeCnt   <= 5'h00;
      wordValid <= 1'b0;
      shiftWord <= '0;
    end else begin
      echoPrev  <= echoedClockOut;
      laneAPrev <= firstSerialLane;
      laneBPrev <= secondSerialLane;
      wordValid <= 1'b0;
      if (echoedClockOut != echoPrev) begin
        if (dualMode) shiftWord.data <= {shiftWord.data[13:0], laneAPrev, laneBPrev};
        else shiftWord.data <= {shiftWord.data[14:0], laneAPrev};
        if (edgeCnt == 5'h00) shiftWord.invalid <= resultInvalid;
        if (edgeCnt == (dualMode ? 5'h07 : 5'h0F)) begin
          edgeCnt   <= 5'h00;
          wordValid <= 1'b1;
        end else begin
          edgeCnt <= edgeCnt + 5'h01;
        end
      end
    end
  end
  assign wordOut = shiftWord;
endmodule : sar_host_model
`default_nettype wire

// File: sar_readout_pkg.sv
// constants and types of the converter control and serial readout
//
// Contract
// - power-down low: outputs off, strobes ignored
// - supply loss resets; reinitialise on supply return
// - strobe rising edge samples and starts conversion
// - first two results after wake are invalid
// - conversion completes within 63ns of strobe
// - sustain 15Msps with acquisition overlapping readout
// - most significant bit on first lane immediately
// - lanes advance on both readout clock edges
// - echo clock edges aligned with data edges
// - readout may overlap the next conversion start
// - dual-lane select enables second lane, two bits
// - single-lane test word is 1010 0000 0111 1111
// - pattern-force high; two-lane word 1100 1100 0011 1111
`default_nettype none
package sar_readout_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 10000;
  localparam int CONV_TIME_NS   = 63;
  localparam int CONV_CYC_RAW   = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int CONV_CYCLES    = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam int WAKE_SETTLE_MS = 20;
  localparam int CNT_W          = 4;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);

  // -----------------------------------------------------------------
  // data and patterns
  // -----------------------------------------------------------------
  localparam int WORD_W     = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [WORD_W-1:0] PATTERN_ONE_LANE = 16'hA07F;
  localparam logic [WORD_W-1:0] PATTERN_TWO_LANE = 16'hCC3F;
  localparam logic [1:0] INVALID_CONVS = 2'h2;
  localparam logic [4:0] EDGES_ONE_LANE = 5'h10;
  localparam logic [4:0] EDGES_TWO_LANE = 5'h08;
  localparam int MSB     = WORD_W - 1;
  localparam int NEXT_B  = WORD_W - 2;

  typedef enum logic [1:0] {PH_OFF, PH_IDLE, PH_CONV} phase_t;

  typedef struct packed {
    logic              invalid;
    logic [WORD_W-1:0] data;
  } result_t;

  localparam int RESULT_W = $bits(result_t);
endpackage : sar_readout_pkg
`default_nettype wire
